// ===== abc_defs.svh
// Purpose: constants for the converter board bus control
// Assumes: ref_clk_i at 250 MHz
// Notes:   included by both design files; the package holds only types
`ifndef ABC_DEFS_SVH
`define ABC_DEFS_SVH
`define ABC_CMD_GROUP      3'h1
`define ABC_CMD_CHAN_GAIN  3'h5
`define ABC_CMD_MODE       3'h6
`define ABC_CMD_RD_LOW     3'h2
`define ABC_CMD_RD_HIGH    3'h3
`define ABC_CMD_RD_SCAN    3'h4
`define ABC_CMD_RD_REPEAT  3'h5
`define ABC_GROUP_DEFAULT  8'h30
`define ABC_CHAN_RESET     4'h1
`define ABC_GAIN_RESET     4'h0
`define ABC_GAIN_MAX       4'ha
`define ABC_MODE_RES_BIT   0
`define ABC_MODE_SCAN_BIT  1
`define ABC_CLK_MHZ        250
`define ABC_SETTLE_LONG_US 250
`define ABC_SETTLE_SHORT_US 80
`define ABC_DONE_SEL_INT   3'h4
`endif

// ===== abc_pkg.sv
// Purpose: shared types of the converter board bus control
// Assumes: abc_defs.svh provides the numeric constants
// Notes:   types only
`default_nettype none
package abc_pkg;
   typedef struct packed {
      logic [2:0] io_cmd;
      logic       bus_direction;
      logic       timing_pulse_a;
      logic       timing_pulse_b;
   } abc_bus_ctl_t;
   typedef struct packed {
      logic [3:0] gain;
      logic [3:0] channel;
      logic       res_8bit;
      logic       scan_on;
   } abc_cfg_t;
   typedef enum logic [1:0] {ABC_IDLE, ABC_SETTLE, ABC_CONVERT} abc_state_t;
endpackage : abc_pkg
`default_nettype wire

// ===== abc_settle_timer.sv
// Purpose: settling delay counter for the converter board
// Assumes: start is a one-cycle pulse on ref_clk_i
// Notes:   a new start restarts the count
`include "abc_defs.svh"
`default_nettype none
module abc_settle_timer #(
   parameter int CW = 16
) (
   input  wire logic          ref_clk_i,
   input  wire logic          rst_b_i,
   input  wire logic          start_i,
   input  wire logic [CW-1:0] cycles_i,
   output logic               busy_o,
   output logic               done_o
);
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic          done_q;
   logic          done_d;

   always_comb begin
      cnt_d  = cnt_q;
      done_d = 1'b0;
      if (start_i) begin
         cnt_d = cycles_i;
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - CW'(1);
         done_d = (cnt_q == CW'(1));
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         cnt_q  <= '0;
         done_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         done_q <= done_d;
      end
   end

   assign busy_o = (cnt_q != '0);
   assign done_o = done_q;
endmodule : abc_settle_timer
`default_nettype wire

// ===== abc_board_ctl.sv
// Purpose: bus decode, settings and conversion sequencing of an ADC board
// Assumes: backplane pins asynchronous to ref_clk_i; converter result port is ref_clk_i logic
// Notes:   completion line choice is a strap caught after reset release
`include "abc_defs.svh"
`default_nettype none
module abc_board_ctl
   import abc_pkg::*;
#(
   parameter int          CW         = 16,
   parameter logic [7:0]  GROUP_CODE = `ABC_GROUP_DEFAULT,
   parameter int          SETTLE_LONG  = `ABC_SETTLE_LONG_US * `ABC_CLK_MHZ,
   parameter int          SETTLE_SHORT = `ABC_SETTLE_SHORT_US * `ABC_CLK_MHZ
) (
   input  wire logic          ref_clk_i,
   input  wire logic          rst_b_i,
   input  wire abc_bus_ctl_t  bus_ctl_i,
   input  wire logic [7:0]    cpu_byte_lines_i,
   output logic [7:0]         cpu_byte_lines_o,
   output logic               cpu_byte_lines_oe_b_o,
   input  wire logic [2:0]    done_line_select_link_i,
   input  wire logic          differential_i,
   input  wire logic          short_cycle_i,
   output logic               conv_start_o,
   output logic               conv_res_8bit_o,
   output logic               conv_short_o,
   input  wire logic          conv_done_i,
   input  wire logic [11:0]   conv_result_i,
   output abc_cfg_t           cfg_o,
   output logic               ext_flag_1_b_o,
   output logic               ext_flag_2_b_o,
   output logic               ext_flag_3_b_o,
   output logic               ext_flag_4_b_o,
   output logic               int_req_b_o
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   localparam int SW = 16;
   logic [SW-1:0] sync1_q;
   logic [SW-1:0] sync2_q;
   logic          tpb_prev_q;
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         sync1_q    <= '0;
         sync2_q    <= '0;
         tpb_prev_q <= 1'b0;
      end else begin
         sync1_q    <= {cpu_byte_lines_i, short_cycle_i, differential_i, bus_ctl_i};
         sync2_q    <= sync1_q;
         tpb_prev_q <= sync2_q[0];
      end
   end
   abc_bus_ctl_t bus_s;
   logic [7:0]   data_s;
   logic         diff_s;
   logic         short_s;
   assign bus_s   = sync2_q[5:0];
   assign diff_s  = sync2_q[6];
   assign short_s = sync2_q[7];
   assign data_s  = sync2_q[15:8];
   logic tpb_rise;
   assign tpb_rise = bus_s.timing_pulse_b & ~tpb_prev_q;
   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   logic       selected_q;
   logic       selected_d;
   logic       io_active;
   logic       wr_cmd;
   logic       rd_cmd;
   assign io_active = (bus_s.io_cmd != 3'h0);
   assign wr_cmd = io_active & ~bus_s.bus_direction & tpb_rise;
   assign rd_cmd = io_active & bus_s.bus_direction & tpb_rise;
   logic wr_group;
   logic wr_chan;
   logic wr_mode;
   logic rd_low;
   logic rd_high;
   logic rd_scan;
   logic rd_rep;
   assign wr_group = wr_cmd & (bus_s.io_cmd == `ABC_CMD_GROUP);
   assign wr_chan  = wr_cmd & selected_q & (bus_s.io_cmd == `ABC_CMD_CHAN_GAIN);
   assign wr_mode  = wr_cmd & selected_q & (bus_s.io_cmd == `ABC_CMD_MODE);
   assign rd_low   = rd_cmd & selected_q & (bus_s.io_cmd == `ABC_CMD_RD_LOW);
   assign rd_high  = rd_cmd & selected_q & (bus_s.io_cmd == `ABC_CMD_RD_HIGH);
   assign rd_scan  = rd_cmd & selected_q & (bus_s.io_cmd == `ABC_CMD_RD_SCAN);
   assign rd_rep   = rd_cmd & selected_q & (bus_s.io_cmd == `ABC_CMD_RD_REPEAT);
   // ----------------------------------------------------------------
   // settings, flag and sequencer
   // ----------------------------------------------------------------
   abc_cfg_t   cfg_q;
   abc_cfg_t   cfg_d;
   logic       avail_q;
   logic       avail_d;
   abc_state_t st_q;
   abc_state_t st_d;
   logic       tmr_start;
   logic [CW-1:0] tmr_cycles;
   logic       tmr_done;
   logic       tmr_busy;
   logic [11:0] result_q;
   logic [11:0] result_d;
   logic [2:0] line_sel_q;
   logic       strap_q;
   logic [3:0] chan_mask;
   assign chan_mask = diff_s ? 4'h7 : 4'hf;

   always_comb begin
      selected_d = selected_q;
      cfg_d      = cfg_q;
      avail_d    = avail_q;
      st_d       = st_q;
      result_d   = result_q;
      tmr_start  = 1'b0;
      tmr_cycles = CW'(SETTLE_LONG);
      if (wr_group) begin
         selected_d = (data_s == GROUP_CODE);
      end
      if (wr_mode) begin
         cfg_d.res_8bit = data_s[`ABC_MODE_RES_BIT];
         cfg_d.scan_on  = data_s[`ABC_MODE_SCAN_BIT];
      end
      if (rd_high | rd_scan | rd_rep) begin
         avail_d = 1'b0;
      end
      case (st_q)
         ABC_IDLE: begin
            if (wr_chan) begin
               cfg_d.gain    = (data_s[7:4] > `ABC_GAIN_MAX) ? `ABC_GAIN_MAX : data_s[7:4];
               cfg_d.channel = data_s[3:0] & chan_mask;
               tmr_start     = 1'b1;
               st_d          = ABC_SETTLE;
            end else if (rd_scan) begin
               if (cfg_q.scan_on) begin
                  cfg_d.channel = (cfg_q.channel + 4'h1) & chan_mask;
               end
               tmr_start = 1'b1;
               st_d      = ABC_SETTLE;
            end else if (rd_rep) begin
               tmr_cycles = CW'(SETTLE_SHORT);
               tmr_start  = 1'b1;
               st_d       = ABC_SETTLE;
            end
         end
         ABC_SETTLE: begin
            if (tmr_done) begin
               st_d = ABC_CONVERT;
            end
         end
         ABC_CONVERT: begin
            if (conv_done_i) begin
               result_d = conv_result_i;
               avail_d  = 1'b1;                   // set wins over a same-cycle clear
               st_d     = ABC_IDLE;
            end
         end
         default: begin
            st_d = ABC_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         selected_q <= 1'b0;
         cfg_q      <= '{gain: `ABC_GAIN_RESET, channel: `ABC_CHAN_RESET, res_8bit: 1'b0, scan_on: 1'b0};
         avail_q    <= 1'b0;
         st_q       <= ABC_IDLE;
         result_q   <= '0;
      end else begin
         selected_q <= selected_d;
         cfg_q      <= cfg_d;
         avail_q    <= avail_d;
         st_q       <= st_d;
         result_q   <= result_d;
      end
   end

   // strap caught on the first clocked cycle after release, not under reset
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         strap_q    <= 1'b0;
         line_sel_q <= 3'h0;
      end else if (!strap_q) begin
         strap_q    <= 1'b1;
         line_sel_q <= done_line_select_link_i;
      end
   end

   abc_settle_timer #(.CW(CW)) u_settle (
      .ref_clk_i (ref_clk_i),
      .rst_b_i   (rst_b_i),
      .start_i   (tmr_start),
      .cycles_i  (tmr_cycles),
      .busy_o    (tmr_busy),
      .done_o    (tmr_done)
   );
   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   logic       start_q;
   logic [7:0] rd_byte_q;
   logic       drive_q;
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         start_q   <= 1'b0;
         rd_byte_q <= '0;
         drive_q   <= 1'b0;
      end else begin
         start_q <= (st_q == ABC_SETTLE) & tmr_done;
         drive_q <= selected_q & io_active & bus_s.bus_direction &
                    (bus_s.io_cmd inside {`ABC_CMD_RD_LOW, `ABC_CMD_RD_HIGH,
                                          `ABC_CMD_RD_SCAN, `ABC_CMD_RD_REPEAT});
         rd_byte_q <= (bus_s.io_cmd == `ABC_CMD_RD_LOW) ? {result_q[3:0], 4'h0} : result_q[11:4];
      end
   end
   assign cpu_byte_lines_o      = rd_byte_q;
   assign cpu_byte_lines_oe_b_o = ~drive_q;
   assign conv_start_o    = start_q;
   assign conv_res_8bit_o = cfg_q.res_8bit;
   assign conv_short_o    = short_s;
   assign cfg_o           = cfg_q;
   assign ext_flag_1_b_o  = ~(avail_q & (line_sel_q == 3'h0));
   assign ext_flag_2_b_o  = ~(avail_q & (line_sel_q == 3'h1));
   assign ext_flag_3_b_o  = ~(avail_q & (line_sel_q == 3'h2));
   assign ext_flag_4_b_o  = ~(avail_q & (line_sel_q == 3'h3));
   assign int_req_b_o     = ~(avail_q & (line_sel_q == `ABC_DONE_SEL_INT));

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_settle_done;
      (st_q == ABC_SETTLE) ##0 tmr_done;
   endsequence
   AST_START_AFTER_SETTLE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      s_settle_done |=> conv_start_o) else $error("start missing after settle");
   AST_SETTLE_TIMING: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (st_q == ABC_SETTLE) |-> (tmr_busy || tmr_done)) else $error("settle state without running timer");
   AST_CLEAR_FLAG: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (rd_high && st_q != ABC_CONVERT) |=> !avail_q) else $error("flag not cleared by read");
   AST_DRIVE_ONLY_SELECTED: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      !cpu_byte_lines_oe_b_o |-> $past(selected_q)) else $error("bus driven while unselected");
   AST_GROUP_SELECT: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      wr_group |=> (selected_q == ($past(data_s) == GROUP_CODE))) else $error("group decode wrong");
   AST_CHAN_LOAD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (wr_chan && st_q == ABC_IDLE) |=> (st_q == ABC_SETTLE && cfg_q.channel == ($past(data_s[3:0]) & chan_mask)))
      else $error("channel load wrong");
   AST_MODE_LOAD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      wr_mode |=> (cfg_q.res_8bit == $past(data_s[0]) && cfg_q.scan_on == $past(data_s[1])))
      else $error("mode load wrong");
   AST_GAIN_RANGE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      cfg_q.gain <= `ABC_GAIN_MAX) else $error("gain out of range");
   AST_ONE_DONE_LINE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      $onehot0(~{ext_flag_1_b_o, ext_flag_2_b_o, ext_flag_3_b_o, ext_flag_4_b_o, int_req_b_o}))
      else $error("more than one done line");
   AST_RESET_CFG: assert property (@(posedge ref_clk_i)
      !rst_b_i |=> (cfg_q.channel == `ABC_CHAN_RESET && !cfg_q.res_8bit && !cfg_q.scan_on && !avail_q))
      else $error("reset settings wrong");
endmodule : abc_board_ctl
`default_nettype wire

// ===== abc_cpu_model.sv
// Purpose: backplane processor model issuing two-level io instructions
// Assumes: processor-driven pins change just after the falling edge of ref_clk_i
// Notes:   released data lines show the inverse of their last value
`default_nettype none
module abc_cpu_model
   import abc_pkg::*;
(
   input  wire logic       ref_clk_i,
   input  wire logic [7:0] brd_byte_i,
   input  wire logic       brd_oe_b_i,
   output abc_bus_ctl_t    bus_ctl_o,
   output logic [7:0]      bus_byte_o,
   output logic            clash_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cpu_byte = 8'h00;
   logic       cpu_drv  = 1'b0;
   logic [7:0] last_q   = 8'h00;
   initial begin
      bus_ctl_o = '0;
      clash_o   = 1'b0;
   end
   // floating lines toggle so a stale value can never pass for a read
   always_comb begin
      if (!brd_oe_b_i) bus_byte_o = brd_byte_i;
      else if (cpu_drv) bus_byte_o = cpu_byte;
      else bus_byte_o = ~last_q;
   end
   always @(posedge ref_clk_i) begin
      last_q <= bus_byte_o;
      if (!brd_oe_b_i && !bus_ctl_o.bus_direction) clash_o <= 1'b1;
   end
   // -----------------------------------------
   // one machine cycle: pulse a, then pulse b
   // -----------------------------------------
   task automatic cycle_io(input logic [2:0] cmd, input logic dir, input logic [7:0] data,
                           output logic [7:0] rd, output logic drove);
      drove = 1'b0;
      @(negedge ref_clk_i);
      bus_ctl_o.io_cmd         = cmd;
      bus_ctl_o.bus_direction  = dir;
      cpu_byte                 = data;
      cpu_drv                  = !dir;
      bus_ctl_o.timing_pulse_a = 1'b1;
      @(negedge ref_clk_i);
      bus_ctl_o.timing_pulse_a = 1'b0;
      repeat (5) begin
         @(negedge ref_clk_i);
         drove = drove | !brd_oe_b_i;
      end
      rd = bus_byte_o;
      bus_ctl_o.timing_pulse_b = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      bus_ctl_o.timing_pulse_b = 1'b0;
      // data held well past the synchronised pulse b
      repeat (4) @(negedge ref_clk_i);
      bus_ctl_o.io_cmd = 3'h0;
      cpu_drv          = 1'b0;
      repeat (4) @(negedge ref_clk_i);
   endtask : cycle_io
endmodule : abc_cpu_model
`default_nettype wire

// ===== tb_top.sv
// Purpose: self-checking bench for the converter board bus control
// Assumes: shortened settling counts, converter stand-in with fixed latency
// Notes:   ordinary commands run from a table, the rest by hand
`default_nettype none
module tb_top
   import abc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SL = 40;
   localparam int SS = 12;
   typedef struct packed {
      logic [2:0] cmd;
      logic [7:0] data;
      logic       sel;
      logic       conv;
      logic [9:0] cfg;
   } abc_row_t;
   logic         ref_clk_i = 1'b0;
   logic         rst_b_i   = 1'b0;
   logic         short_cyc = 1'b0;
   logic         diff      = 1'b0;
   logic [2:0]   link      = 3'h0;
   logic [2:0]   conv_sr   = 3'h0;
   abc_bus_ctl_t bus_ctl;
   abc_cfg_t     cfg;
   logic [7:0]   bus_byte, brd_byte, rd;
   logic         oe_b, clash, drove, conv_start, conv_done, res8, conv_short;
   logic [4:0]   flags;
   int           n_errors = 0;
   int           checks   = 0;
   int           n_starts = 0;
   int           n, s0;
   abc_row_t     rows [9] = '{
      '{3'h1, 8'h30, 1'b1, 1'b0, 10'h004}, '{3'h1, 8'h31, 1'b0, 1'b0, 10'h004},
      '{3'h5, 8'h44, 1'b0, 1'b0, 10'h004}, '{3'h1, 8'h30, 1'b1, 1'b0, 10'h004},
      '{3'h6, 8'h01, 1'b1, 1'b0, 10'h006}, '{3'h5, 8'h23, 1'b1, 1'b1, 10'h08e},
      '{3'h6, 8'hfe, 1'b1, 1'b0, 10'h08d}, '{3'h5, 8'h7f, 1'b1, 1'b1, 10'h1fd},
      '{3'h5, 8'hcf, 1'b1, 1'b1, 10'h2bd}};
   always #2 ref_clk_i = ~ref_clk_i;
   abc_cpu_model cpu (.ref_clk_i(ref_clk_i), .brd_byte_i(brd_byte), .brd_oe_b_i(oe_b), .bus_ctl_o(bus_ctl),
                      .bus_byte_o(bus_byte), .clash_o(clash));
   abc_board_ctl #(.SETTLE_LONG(SL), .SETTLE_SHORT(SS)) uut (
      .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .bus_ctl_i(bus_ctl), .cpu_byte_lines_i(bus_byte),
      .cpu_byte_lines_o(brd_byte), .cpu_byte_lines_oe_b_o(oe_b), .done_line_select_link_i(link),
      .differential_i(diff), .short_cycle_i(short_cyc), .conv_start_o(conv_start), .conv_res_8bit_o(res8),
      .conv_short_o(conv_short), .conv_done_i(conv_done), .conv_result_i({cfg.channel, cfg.gain, 4'h9}),
      .cfg_o(cfg), .ext_flag_1_b_o(flags[0]), .ext_flag_2_b_o(flags[1]), .ext_flag_3_b_o(flags[2]),
      .ext_flag_4_b_o(flags[3]), .int_req_b_o(flags[4]));
   // converter stand-in: result tagged with channel and gain, done three clocks after start
   always @(posedge ref_clk_i) begin
      conv_sr <= {conv_sr[1:0], conv_start};
      if (conv_start === 1'b1) n_starts <= n_starts + 1;
   end
   assign conv_done = conv_sr[2];
   // -----------------------------------------
   // shared tasks
   // -----------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic conv_wait(output int cnt);
      cnt = 0;
      while (conv_start !== 1'b1 && cnt < 400) begin
         @(negedge ref_clk_i);
         cnt++;
      end
      checks++;
      if (cnt >= 400) begin
         n_errors++;
         $display("CHECK FAILED conv start expected 1 seen 0");
         stop_test();
      end
      repeat (6) @(negedge ref_clk_i);
   endtask : conv_wait
   task automatic do_reset(input logic [2:0] l);
      @(negedge ref_clk_i);
      rst_b_i = 1'b0;
      link    = l;
      repeat (3) @(negedge ref_clk_i);
      rst_b_i = 1'b1;
      repeat (3) @(negedge ref_clk_i);
   endtask : do_reset
   // -----------------------------------------
   // main sequence
   // -----------------------------------------
   initial begin
      do_reset(3'h0);
      chk("cfg after clear", 12'h004, 12'(cfg));
      chk("flags after clear", 12'h01f, 12'(flags));
      chk("oe after clear", 12'h001, 12'(oe_b));
      $display("reset test done");
      foreach (rows[i]) begin
         s0 = n_starts;
         cpu.cycle_io(rows[i].cmd, 1'b0, rows[i].data, rd, drove);
         if (rows[i].conv) conv_wait(n);
         else repeat (SL + 20) @(negedge ref_clk_i);
         chk("starts", 12'(rows[i].conv), 12'(n_starts - s0));
         chk("cfg", 12'(rows[i].cfg), 12'(cfg));
         chk("res line", 12'(rows[i].cfg[1]), 12'(res8));
         if (rows[i].conv) chk("flag set", 12'h01e, 12'(flags));
         cpu.cycle_io(3'h3, 1'b1, 8'h00, rd, drove);
         chk("drove", 12'(rows[i].sel), 12'(drove));
         if (rows[i].conv) begin
            chk("high byte", {4'h0, rows[i].cfg[5:2], rows[i].cfg[9:6]}, 12'(rd));
            chk("flag clear", 12'h01f, 12'(flags));
         end
         if (rows[i].conv && !rows[i].cfg[1]) begin
            cpu.cycle_io(3'h2, 1'b1, 8'h00, rd, drove);
            chk("low nibble", 12'h090, 12'(rd));
         end
         $display("row %0d done", i);
      end
      // channel f wraps to 0 on a scanning read
      cpu.cycle_io(3'h4, 1'b1, 8'h00, rd, drove);
      chk("scan byte", 12'h0fa, 12'(rd));
      chk("scan chan", 12'h000, 12'(cfg.channel));
      chk("scan flag", 12'h01f, 12'(flags));
      conv_wait(n);
      chk("long settle", 12'h001, 12'(n >= 28 && n <= 44));
      cpu.cycle_io(3'h5, 1'b1, 8'h00, rd, drove);
      chk("repeat byte", 12'h00a, 12'(rd));
      conv_wait(n);
      chk("short settle", 12'h001, 12'(n >= 1 && n <= 16));
      chk("repeat chan", 12'h000, 12'(cfg.channel));
      $display("scan test done");
      short_cyc = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      chk("short cycle", 12'h001, 12'(conv_short));
      short_cyc = 1'b0;
      chk("bus clash", 12'h000, 12'(clash));
      // every completion line choice, each behind a mid-run clear
      for (int l = 0; l < 5; l++) begin
         do_reset(3'(l));
         chk("cfg after clear", 12'h004, 12'(cfg));
         cpu.cycle_io(3'h1, 1'b0, 8'h30, rd, drove);
         cpu.cycle_io(3'h5, 1'b0, 8'h12, rd, drove);
         conv_wait(n);
         chk("done line", 12'(5'h1f & ~(5'h01 << l)), 12'(flags));
      end
      $display("done line test done");
      // eight differential channels: channel bit 3 is a don't care
      diff = 1'b1;
      cpu.cycle_io(3'h5, 1'b0, 8'h1f, rd, drove);
      conv_wait(n);
      chk("diff chan", 12'h007, 12'(cfg.channel));
      chk("diff cfg", 12'h05c, 12'(cfg));
      $display("differential test done");
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
